// file: verilog/drb_pkg.sv
// Purpose: shared constants and carriers for the drive register bridge
// Assumes: 125 MHz ref_clk, 8 ns period
// Notes:   times kept in ns, cycle counts derived here
package drb_pkg;
  localparam int CLK_PERIOD_NS   = 8;
  // least times round up
  localparam int DESKEW_NS       = 220;
  localparam int DESKEW_CYC      = (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS       = 85;
  localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NS       = 200;
  localparam int SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DRIVE_RESPONSE_TIMEOUT_NS = 1500;
  localparam int DRIVE_RESPONSE_TIMEOUT_CYC =
    (DRIVE_RESPONSE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W           = 8;
  localparam int ADDR_W          = 16;
  localparam int EXT_W           = 2;
  localparam int EXT_LSB         = 8;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [1:0]  EXT_RST  = 2'h0;

  typedef enum logic [5:0] {
    DRB_IDLE   = 6'b00_0001,
    DRB_DESKEW = 6'b00_0010,
    DRB_DEMAND = 6'b00_0100,
    DRB_SETTLE = 6'b00_1000,
    DRB_LOCAL  = 6'b01_0000,
    DRB_DONE   = 6'b10_0000
  } drb_state_e;

  // host cycle qualifiers from the address decoder
  typedef struct packed {
    logic device_selected;
    logic address_valid;
    logic local_select;
    logic attn_summary;
    logic cs1_sel;
    logic buf_sel;
    logic addr_sel;
    logic write_direction;
    logic read_pause_cycle;
    logic hi_byte;
    logic lo_byte;
    logic xfer_func;
  } drb_req_s;

  typedef struct packed {
    logic [1:0]  ext;
    logic [15:0] addr;
  } drb_addr_s;
endpackage

// file: verilog/drb_sync3.sv
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: input asynchronous to ref_clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
module drb_sync3 (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic [2:0] s_r;
  logic [2:0] s_nxt;
  logic       q_r;
  logic       q_nxt;

  always_comb begin
    s_nxt = {s_r[1:0], d};
    q_nxt = (s_r[1] == s_r[2]) ? s_r[1] : q_r;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= 3'h0;
      q_r <= 1'b0;
    end else begin
      s_r <= s_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// file: verilog/drb_addr_cnt.sv
// Purpose: transfer address counter with extension bits
// Assumes: strobes single cycle, same clock
// Notes:   clear beats load beats count
`timescale 1ns/1ns
module drb_addr_cnt (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ctl_clear,
  input  wire logic              load,
  input  wire logic              hi_byte,
  input  wire logic              lo_byte,
  input  wire logic              ext_load,
  input  wire logic [15:0]       wdata,
  input  wire logic              count_strobe,
  input  wire logic              count_downward,
  input  wire logic              address_hold,
  output drb_pkg::drb_addr_s     addr
);
  drb_pkg::drb_addr_s a_r;
  drb_pkg::drb_addr_s a_nxt;

  always_comb begin
    a_nxt = a_r;
    if (ctl_clear) begin
      a_nxt.addr = drb_pkg::ADDR_RST;
    end else if (load) begin
      if (hi_byte) a_nxt.addr[15:8] = wdata[15:8];
      if (lo_byte) a_nxt.addr[7:0] = wdata[7:0];
    end else if (count_strobe && !address_hold) begin
      a_nxt.addr = count_downward ? a_r.addr - 16'h0002
                                  : a_r.addr + 16'h0002;
    end
    if (ext_load) begin
      a_nxt.ext = wdata[drb_pkg::EXT_LSB +: drb_pkg::EXT_W];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      a_r.addr <= drb_pkg::ADDR_RST;
      a_r.ext  <= drb_pkg::EXT_RST;
    end else begin
      a_r <= a_nxt;
    end
  end

  assign addr = a_r;
endmodule

// file: verilog/drb_bridge.sv
// Purpose: host register cycle bridge to drive bus, plus dma address
// Assumes: master_sync and drive_transfer_ack are pins; rest same clock
// Notes:   timing by counted cycles after synchronised master_sync
`timescale 1ns/1ns
// What this block does
// - attention summary: ignore acks, wait 1.5 us
// - remote read: 200 ns settle then slave_sync
// - local: strobe at 85 ns, sync at end
// - demand starts 1.5 us timer; response clears
// - timeout: slave_sync, error unless attention summary
// - deselect clears missing drive error; timer only when idle
// - local register access suppresses demand
// - high byte write to csr one suppresses
// - transfer during transfer raises collision block
// - illegal address: no demand, no slave_sync
// - dma address onto port a or b
// - port_select clear after power up
// - buffer read pops silo unless read pause
// - silo_pop with slave_sync until master_sync drops
// - address register loads per byte enables
// - extension bits load on ready high write
// - controller clear zeroes transfer address, not extension bits
// - count on strobe end, direction selectable
// - address_hold stops transfer address counting
// - demand 220 ns after master_sync
module drb_bridge (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              master_sync,
  input  drb_pkg::drb_req_s      req,
  input  wire logic [15:0]       wdata,
  input  wire logic              drive_transfer_ack,
  input  wire logic              xfer_busy,
  input  wire logic              controller_ready,
  input  wire logic              ctl_clear,
  input  wire logic              port_select_set,
  input  wire logic              port_select_clr,
  input  wire logic              count_downward,
  input  wire logic              address_hold,
  input  wire logic              dma_cycle,
  input  wire logic              address_drive_strobe,
  output logic                   slave_sync,
  output logic                   drive_demand,
  output logic                   local_register_strobe,
  output logic                   demand_suppress,
  output logic                   transfer_collision_block,
  output logic                   missing_drive_error,
  output logic                   silo_pop,
  output logic                   port_select,
  output logic                   port_a_en,
  output logic                   port_b_en,
  output drb_pkg::drb_addr_s     port_a_addr,
  output drb_pkg::drb_addr_s     port_b_addr,
  output drb_pkg::drb_addr_s     transfer_address
);
  localparam int DESKEW_CYC  = drb_pkg::DESKEW_CYC;
  localparam int STROBE_CYC  = drb_pkg::STROBE_CYC;
  localparam int SETTLE_CYC  = drb_pkg::SETTLE_CYC;
  localparam int TIMEOUT_CYC = drb_pkg::DRIVE_RESPONSE_TIMEOUT_CYC;

  logic master_sync_s;
  logic ack_s;
  drb_sync3 u_master_sync (.ref_clk(ref_clk), .rst(rst), .d(master_sync), .q(master_sync_s));
  drb_sync3 u_ack (.ref_clk(ref_clk), .rst(rst), .d(drive_transfer_ack), .q(ack_s));

  drb_pkg::drb_state_e         st_r;
  drb_pkg::drb_state_e         st_nxt;
  logic [drb_pkg::TMR_W-1:0]   tmr_r;
  logic [drb_pkg::TMR_W-1:0]   tmr_nxt;
  logic                        slave_sync_r;
  logic                        slave_sync_nxt;
  logic                        dem_r;
  logic                        dem_nxt;
  logic                        strb_r;
  logic                        strb_nxt;
  logic                        ned_r;
  logic                        ned_nxt;
  logic                        pop_r;
  logic                        pop_nxt;
  logic                        supp_r;
  logic                        supp_nxt;
  logic                        coll_r;
  logic                        coll_nxt;
  logic                        psel_r;
  logic                        psel_nxt;
  logic                        ads_d_r;
  logic                        odd_cs1;
  logic                        coll;
  logic                        supp;
  logic                        addr_load;
  logic                        ext_load;
  logic                        cnt_strobe;
  drb_pkg::drb_addr_s          addr;

  // suppression terms
  always_comb begin
    odd_cs1 = req.cs1_sel && req.write_direction && req.hi_byte && !req.lo_byte;
    coll    = req.xfer_func && req.write_direction && xfer_busy;
    supp    = req.local_select || odd_cs1 || coll;
  end

  // host cycle sequencer
  always_comb begin
    st_nxt   = st_r;
    tmr_nxt  = tmr_r;
    slave_sync_nxt = slave_sync_r;
    dem_nxt  = dem_r;
    strb_nxt = 1'b0;
    ned_nxt  = ned_r;
    pop_nxt  = pop_r;
    supp_nxt = supp_r;
    coll_nxt = coll_r;
    case (st_r)
      drb_pkg::DRB_IDLE: begin
        tmr_nxt = '0;
        // illegal address: no state change, no answer
        if (master_sync_s && req.device_selected && req.address_valid) begin
          supp_nxt = supp;
          coll_nxt = coll;
          st_nxt   = supp ? drb_pkg::DRB_LOCAL : drb_pkg::DRB_DESKEW;
        end
      end
      drb_pkg::DRB_DESKEW: begin
        tmr_nxt  = tmr_r + 1'b1;
        // word writes to csr one still clock its local high byte
        strb_nxt = (32'(tmr_r) + 1 == STROBE_CYC);
        if (!master_sync_s) begin
          st_nxt = drb_pkg::DRB_DONE;
        end else if (32'(tmr_r) + 1 >= DESKEW_CYC) begin
          dem_nxt = 1'b1;
          tmr_nxt = '0;
          st_nxt  = drb_pkg::DRB_DEMAND;
        end
      end
      drb_pkg::DRB_DEMAND: begin
        tmr_nxt = tmr_r + 1'b1;
        if (ack_s && !req.attn_summary) begin
          tmr_nxt = '0;
          dem_nxt = 1'b0;
          if (req.write_direction) begin
            slave_sync_nxt = 1'b1;
            st_nxt   = drb_pkg::DRB_DONE;
          end else begin
            st_nxt = drb_pkg::DRB_SETTLE;
          end
        end else if (32'(tmr_r) + 1 >= TIMEOUT_CYC) begin
          dem_nxt  = 1'b0;
          slave_sync_nxt = 1'b1;
          ned_nxt  = !req.attn_summary;
          st_nxt   = drb_pkg::DRB_DONE;
        end
      end
      drb_pkg::DRB_SETTLE: begin
        tmr_nxt = tmr_r + 1'b1;
        if (32'(tmr_r) + 1 >= SETTLE_CYC) begin
          slave_sync_nxt = 1'b1;
          pop_nxt  = req.buf_sel && !req.read_pause_cycle;
          st_nxt   = drb_pkg::DRB_DONE;
        end
      end
      drb_pkg::DRB_LOCAL: begin
        tmr_nxt  = tmr_r + 1'b1;
        strb_nxt = (32'(tmr_r) + 1 == STROBE_CYC);
        if (strb_r) begin
          slave_sync_nxt = 1'b1;
          pop_nxt  = req.buf_sel && !req.write_direction
                     && !req.read_pause_cycle;
          st_nxt   = drb_pkg::DRB_DONE;
        end
      end
      drb_pkg::DRB_DONE: begin
        if (!master_sync_s) begin
          slave_sync_nxt = 1'b0;
          pop_nxt  = 1'b0;
          supp_nxt = 1'b0;
          coll_nxt = 1'b0;
          st_nxt   = drb_pkg::DRB_IDLE;
        end
      end
      default: begin
        st_nxt = drb_pkg::DRB_IDLE;
      end
    endcase
    if (!req.device_selected && !master_sync_s) begin
      ned_nxt = 1'b0;
      if (st_r == drb_pkg::DRB_IDLE) tmr_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r   <= drb_pkg::DRB_IDLE;
      tmr_r  <= '0;
      slave_sync_r <= 1'b0;
      dem_r  <= 1'b0;
      strb_r <= 1'b0;
      ned_r  <= 1'b0;
      pop_r  <= 1'b0;
      supp_r <= 1'b0;
      coll_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      tmr_r  <= tmr_nxt;
      slave_sync_r <= slave_sync_nxt;
      dem_r  <= dem_nxt;
      strb_r <= strb_nxt;
      ned_r  <= ned_nxt;
      pop_r  <= pop_nxt;
      supp_r <= supp_nxt;
      coll_r <= coll_nxt;
    end
  end

  // address register loads ride the local strobe
  always_comb begin
    addr_load  = strb_r && req.addr_sel && req.write_direction;
    ext_load   = strb_r && req.cs1_sel && req.write_direction
                 && req.hi_byte && controller_ready;
    cnt_strobe = ads_d_r && !address_drive_strobe;
    psel_nxt   = psel_r;
    if (port_select_set) psel_nxt = 1'b1;
    if (port_select_clr) psel_nxt = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      psel_r  <= 1'b0;
      ads_d_r <= 1'b0;
    end else begin
      psel_r  <= psel_nxt;
      ads_d_r <= address_drive_strobe;
    end
  end

  drb_addr_cnt u_addr (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .ctl_clear      (ctl_clear),
    .load           (addr_load),
    .hi_byte        (req.hi_byte),
    .lo_byte        (req.lo_byte),
    .ext_load       (ext_load),
    .wdata          (wdata),
    .count_strobe   (cnt_strobe),
    .count_downward (count_downward),
    .address_hold   (address_hold),
    .addr           (addr)
  );

  // port drive registered so outputs leave flops
  logic               pa_en_r;
  logic               pb_en_r;
  drb_pkg::drb_addr_s pa_r;
  drb_pkg::drb_addr_s pb_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pa_en_r <= 1'b0;
      pb_en_r <= 1'b0;
      pa_r    <= '0;
      pb_r    <= '0;
    end else begin
      pa_en_r <= dma_cycle && address_drive_strobe && !psel_r;
      pb_en_r <= dma_cycle && address_drive_strobe && psel_r;
      pa_r    <= (dma_cycle && !psel_r) ? addr : '0;
      pb_r    <= (dma_cycle && psel_r) ? addr : '0;
    end
  end

  assign slave_sync               = slave_sync_r;
  assign drive_demand             = dem_r;
  assign local_register_strobe    = strb_r;
  assign demand_suppress          = supp_r;
  assign transfer_collision_block = coll_r;
  assign missing_drive_error      = ned_r;
  assign silo_pop                 = pop_r;
  assign port_select              = psel_r;
  assign port_a_en                = pa_en_r;
  assign port_b_en                = pb_en_r;
  assign port_a_addr              = pa_r;
  assign port_b_addr              = pb_r;
  assign transfer_address         = addr;

  property p_slave_sync_release;
    @(posedge ref_clk) disable iff (rst)
      (slave_sync_r && !master_sync_s && st_r == drb_pkg::DRB_DONE) |=> !slave_sync_r;
  endproperty
  a_slave_sync_release: assert property (p_slave_sync_release)
    else $error("slave_sync held after master_sync dropped");

  property p_illegal;
    @(posedge ref_clk) disable iff (rst)
      (st_r == drb_pkg::DRB_IDLE && !req.address_valid) |=> !dem_r && !slave_sync_r;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal address answered");

  property p_supp_no_dem;
    @(posedge ref_clk) disable iff (rst)
      supp_r |-> !dem_r;
  endproperty
  a_supp_no_dem: assert property (p_supp_no_dem)
    else $error("demand under suppression");

  property p_pop_with_sync;
    @(posedge ref_clk) disable iff (rst)
      $rose(pop_r) |-> $rose(slave_sync_r);
  endproperty
  a_pop_with_sync: assert property (p_pop_with_sync)
    else $error("silo_pop not aligned to slave_sync");

  property p_strobe_then_sync;
    @(posedge ref_clk) disable iff (rst)
      (strb_r && st_r == drb_pkg::DRB_LOCAL) |=> slave_sync_r && !strb_r;
  endproperty
  a_strobe_then_sync: assert property (p_strobe_then_sync)
    else $error("local sync not at strobe end");

  property p_ned_attn;
    @(posedge ref_clk) disable iff (rst)
      (req.attn_summary && st_r == drb_pkg::DRB_DEMAND) |=> !$rose(ned_r);
  endproperty
  a_ned_attn: assert property (p_ned_attn)
    else $error("missing drive flagged on attention summary");

  property p_psel;
    @(posedge ref_clk) disable iff (rst)
      !(pa_en_r && pb_en_r);
  endproperty
  a_psel: assert property (p_psel)
    else $error("both ports driven");

  property p_ned_clear;
    @(posedge ref_clk) disable iff (rst)
      (!req.device_selected && !master_sync_s) |=> !ned_r;
  endproperty
  a_ned_clear: assert property (p_ned_clear)
    else $error("missing drive error not cleared on deselect");
endmodule

// file: testbench/drb_drive_model.sv
// Purpose: behavioural drive unit answering the drive bus demand
// Assumes: one drive; answer delay and presence set by the bench
// Notes:   ack stays up until demand falls, as a real drive holds it
`timescale 1ns/1ns
module drb_drive_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       drive_demand,
  input  wire logic       respond,
  input  wire logic [7:0] delay,
  output logic            drive_transfer_ack
);
  logic [7:0] cnt;
  initial drive_transfer_ack = 1'b0;
  initial cnt = 8'h00;
  // absent drive never answers, so the timer path is reachable
  always @(posedge ref_clk) begin
    if (rst || !drive_demand) begin
      cnt <= 8'h00;
      drive_transfer_ack <= 1'b0;
    end else begin
      if (cnt != 8'hff) cnt <= cnt + 8'h01;
      if (respond && cnt >= delay) drive_transfer_ack <= 1'b1;
    end
  end
endmodule

// file: testbench/drive_register_access_and_dma_address_bench.sv
// Purpose: self-checking bench for the drive register bridge
// Assumes: 125 MHz ref_clk, drive model on the drive bus
// Notes:   windows allow for the master_sync and ack synchronisers
`timescale 1ns/1ns
module drive_register_access_and_dma_address_bench;
  localparam int SLK = 6;
  logic ref_clk = 1'b0, rst = 1'b1, master_sync = 1'b0;
  drb_pkg::drb_req_s  req = '0;
  logic [15:0]        wdata = 16'h0000;
  logic xfer_busy = 1'b0, controller_ready = 1'b0, ctl_clear = 1'b0;
  logic port_select_set = 1'b0, port_select_clr = 1'b0, count_downward = 1'b0;
  logic address_hold = 1'b0, dma_cycle = 1'b0, address_drive_strobe = 1'b0;
  logic respond = 1'b1;
  logic [7:0] delay = 8'h03;
  logic drive_transfer_ack, slave_sync, drive_demand, local_register_strobe;
  logic demand_suppress, transfer_collision_block, missing_drive_error, silo_pop;
  logic port_select, port_a_en, port_b_en;
  drb_pkg::drb_addr_s port_a_addr, port_b_addr, transfer_address;
  int fails = 0, tests_run = 0;
  int dem_at, ss_at, str_at, ack_at;
  logic saw_sup, saw_col, saw_pop, pop_ss, err_ss;

  always #4 ref_clk = ~ref_clk;

  drb_bridge i_drb_bridge (.ref_clk(ref_clk), .rst(rst), .master_sync(master_sync),
    .req(req), .wdata(wdata), .drive_transfer_ack(drive_transfer_ack),
    .xfer_busy(xfer_busy), .controller_ready(controller_ready), .ctl_clear(ctl_clear),
    .port_select_set(port_select_set), .port_select_clr(port_select_clr),
    .count_downward(count_downward), .address_hold(address_hold), .dma_cycle(dma_cycle),
    .address_drive_strobe(address_drive_strobe), .slave_sync(slave_sync),
    .drive_demand(drive_demand), .local_register_strobe(local_register_strobe),
    .demand_suppress(demand_suppress), .transfer_collision_block(transfer_collision_block),
    .missing_drive_error(missing_drive_error), .silo_pop(silo_pop),
    .port_select(port_select), .port_a_en(port_a_en), .port_b_en(port_b_en),
    .port_a_addr(port_a_addr), .port_b_addr(port_b_addr),
    .transfer_address(transfer_address));
  drb_drive_model i_drb_drive_model (.ref_clk(ref_clk), .rst(rst),
    .drive_demand(drive_demand), .respond(respond), .delay(delay),
    .drive_transfer_ack(drive_transfer_ack));

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  function automatic drb_pkg::drb_req_s mk(input logic loc, wr, hi, lo);
    drb_pkg::drb_req_s r;
    r = '0;
    r.device_selected = 1'b1;
    r.address_valid = 1'b1;
    r.local_select = loc;
    r.write_direction = wr;
    r.hi_byte = hi;
    r.lo_byte = lo;
    return r;
  endfunction

  // one host register cycle; records when each answer appeared
  task automatic host_cycle(input drb_pkg::drb_req_s r, input logic [15:0] d);
    int n;
    dem_at = -1; ss_at = -1; str_at = -1; ack_at = -1;
    saw_sup = 0; saw_col = 0; saw_pop = 0; pop_ss = 0; err_ss = 0;
    @(posedge ref_clk) begin req <= r; wdata <= d; end
    @(posedge ref_clk) master_sync <= 1'b1;
    for (n = 1; n <= 600 && ss_at < 0; n++) begin
      @(negedge ref_clk);
      if (drive_demand === 1'b1 && dem_at < 0) dem_at = n;
      if (drive_transfer_ack === 1'b1 && ack_at < 0) ack_at = n;
      if (local_register_strobe === 1'b1 && str_at < 0) str_at = n;
      if (demand_suppress === 1'b1) saw_sup = 1;
      if (transfer_collision_block === 1'b1) saw_col = 1;
      if (silo_pop === 1'b1) saw_pop = 1;
      if (slave_sync === 1'b1) begin
        ss_at = n; pop_ss = silo_pop; err_ss = missing_drive_error;
      end
    end
    @(posedge ref_clk) master_sync <= 1'b0;
    for (n = 0; n < 12 && slave_sync !== 1'b0; n++) @(negedge ref_clk);
    chk(slave_sync, 1'b0);
    chk(silo_pop, 1'b0);
    @(posedge ref_clk) req <= '0;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic t_local();
    drb_pkg::drb_req_s r;
    r = mk(1, 0, 1, 1);
    host_cycle(r, 16'h0000);
    rng(str_at, drb_pkg::STROBE_CYC, drb_pkg::STROBE_CYC + SLK);
    rng(ss_at, str_at + 1, str_at + 1);
    chk({saw_sup, dem_at < 0}, 2'b11);
    r.buf_sel = 1'b1;
    host_cycle(r, 16'h0000);
    chk({saw_pop, pop_ss}, 2'b11);
    r.read_pause_cycle = 1'b1;
    host_cycle(r, 16'h0000);
    chk(saw_pop, 1'b0);
  endtask

  task automatic t_remote();
    drb_pkg::drb_req_s r;
    host_cycle(mk(0, 1, 1, 1), 16'h0000);
    rng(dem_at, drb_pkg::DESKEW_CYC, drb_pkg::DESKEW_CYC + SLK);
    rng(ss_at - ack_at, 1, SLK);
    chk(err_ss, 1'b0);
    host_cycle(mk(0, 0, 1, 1), 16'h0000);
    rng(ss_at - ack_at, drb_pkg::SETTLE_CYC, drb_pkg::SETTLE_CYC + SLK);
    respond <= 1'b0;
    host_cycle(mk(0, 0, 1, 1), 16'h0000);
    rng(ss_at - dem_at, drb_pkg::DRIVE_RESPONSE_TIMEOUT_CYC, drb_pkg::DRIVE_RESPONSE_TIMEOUT_CYC + 3);
    chk(err_ss, 1'b1);
    chk(missing_drive_error, 1'b0);
    respond <= 1'b1;
    r = mk(0, 0, 1, 1);
    r.attn_summary = 1'b1;
    host_cycle(r, 16'h0000);
    rng(ss_at - dem_at, drb_pkg::DRIVE_RESPONSE_TIMEOUT_CYC, drb_pkg::DRIVE_RESPONSE_TIMEOUT_CYC + 3);
    chk(err_ss, 1'b0);
    r = mk(0, 1, 1, 1);
    r.address_valid = 1'b0;
    host_cycle(r, 16'h0000);
    chk({ss_at < 0, dem_at < 0}, 2'b11);
    r = mk(0, 1, 1, 1);
    r.xfer_func = 1'b1;
    xfer_busy <= 1'b1;
    host_cycle(r, 16'h0000);
    chk({saw_col, dem_at < 0}, 2'b11);
    xfer_busy <= 1'b0;
  endtask

  task automatic strobe_step(input logic [15:0] exp);
    @(posedge ref_clk) address_drive_strobe <= 1'b1;
    @(posedge ref_clk) address_drive_strobe <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(transfer_address.addr, exp);
  endtask

  task automatic t_address();
    drb_pkg::drb_req_s r;
    r = mk(1, 1, 1, 1);
    r.addr_sel = 1'b1;
    host_cycle(r, 16'h1234);
    chk(transfer_address.addr, 16'h1234);
    r.lo_byte = 1'b0;
    host_cycle(r, 16'h5600);
    chk(transfer_address.addr, 16'h5634);
    r.lo_byte = 1'b1; r.hi_byte = 1'b0;
    host_cycle(r, 16'h0078);
    chk(transfer_address.addr, 16'h5678);
    r = mk(0, 1, 1, 1);
    r.cs1_sel = 1'b1;
    controller_ready <= 1'b1;
    host_cycle(r, 16'h0300);
    chk({dem_at > 0, transfer_address.ext}, 3'h7);
    r.lo_byte = 1'b0;
    host_cycle(r, 16'h0200);
    chk({saw_sup, dem_at < 0}, 2'b11);
    chk(transfer_address.ext, 2'h2);
    controller_ready <= 1'b0;
    host_cycle(r, 16'h0100);
    chk(transfer_address.ext, 2'h2);
    strobe_step(16'h567a);
    @(posedge ref_clk) count_downward <= 1'b1;
    strobe_step(16'h5678);
    @(posedge ref_clk) begin address_hold <= 1'b1; dma_cycle <= 1'b1; end
    @(posedge ref_clk) address_drive_strobe <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({port_a_en, port_b_en}, 2'b10);
    chk(port_a_addr, 18'h2_5678);
    @(posedge ref_clk) port_select_set <= 1'b1;
    @(posedge ref_clk) port_select_set <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({port_select, port_a_en, port_b_en}, 3'b101);
    chk(port_b_addr, 18'h2_5678);
    @(posedge ref_clk) address_drive_strobe <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(transfer_address.addr, 16'h5678);
    @(posedge ref_clk) begin port_select_clr <= 1'b1; dma_cycle <= 1'b0; end
    @(posedge ref_clk) begin port_select_clr <= 1'b0; ctl_clear <= 1'b1; end
    @(posedge ref_clk) ctl_clear <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({port_select, transfer_address.addr}, 17'h0_0000);
  endtask

  // the longest cycles run a few hundred clocks; this is far beyond
  initial begin
    #400000;
    fails++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({port_select, slave_sync, drive_demand, missing_drive_error}, 4'h0);
    t_local();
    t_remote();
    t_address();
    final_report();
  end
endmodule
